// ### core/system_address_decode.sv
`timescale 1ns/100ps
`default_nettype none

// Function
// RL1: Reset enables boot ROM overlay replacing lower half of RAM.
// RL2: Software turns ROM overlay on or off by control register write.
// RL3: Overlay on selects ROM for 0000-7FFF, else RAM, never both.
// RL4: ROM select decode spans up to 16 Kbytes of ROM.
// RL5: Address and I/O controls decode into eight banks with own selects.
// RL6: Banks map consecutively, bank 0 at 00H up to bank 7 at 38H.
// RL7: Bank 2 covers 10H-17H for the floppy controller only.
// RL8: Bank 6 covers 30H-37H for the hard disk interface.
// RL9: Display memory reached only by I/O ports, never memory space.
// RL10: Programmed transfers only; no direct memory access path.
// RL11: Floppy controller gives two sources: data request and command done.
// RL12: Video controller raises one interrupt when a command completes.
// RL13: Eight sources prioritised, disk data request highest, J1 lowest.
// RL14: Processor uses mode 2 vectors in table FB00 to FB0F.
// RL15: Control and status registers load start-up values before operation.
// RL16: Status read shows peripheral state including pending interrupts.
// RL17: Acknowledge gets top source only; lower ones wait until serviced.
module system_address_decode #(
	parameter int BANKS = sys_glue_pkg::BANK_COUNT,
	parameter int PORTS_PER_BANK = sys_glue_pkg::PORTS_PER_BANK,
	parameter int IRQ_SOURCES = sys_glue_pkg::IRQ_COUNT
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [15:0] cpuAddr,
	input wire logic [7:0] cpuDataIn,
	input wire logic mreqN,
	input wire logic iorqN,
	input wire logic rdN,
	input wire logic wrN,
	input wire logic m1N,
	output logic [7:0] cpuDataOut,
	output logic cpuDataOe,
	output logic intReqN,
	input wire logic diskDataRequest,
	input wire logic diskCommandDoneIrq,
	input wire logic videoIrq,
	input wire logic keyboardIrq,
	input wire logic timerIrq,
	input wire logic cardJ8Irq,
	input wire logic cardJ7Irq,
	input wire logic busJ1Irq,
	output logic romSelect,
	output logic ramSelect,
	output logic [sys_glue_pkg::ROM_ADDR_WIDTH-1:0] romAddr,
	output logic bank0Select,
	output logic bank1Select,
	output logic bank2Select,
	output logic bank3Select,
	output logic bank4Select,
	output logic bank5Select,
	output logic bank6Select,
	output logic bank7Select,
	output logic displayWriteStrobe,
	output logic [7:0] displayWriteData,
	output logic [7:0] controlTwo
);

	initial begin
		if (BANKS != 8 || IRQ_SOURCES != 8) begin
			$error("system_address_decode: eight banks and eight sources are wired out");
		end
		// Bank decode must end exactly on the last port of the bank space
		if (BANKS * PORTS_PER_BANK - 1 != int'(sys_glue_pkg::BANK_SPACE_LAST_PORT)) begin
			$error("system_address_decode: bank geometry does not match the port map");
		end
		// A ROM wider than the overlay window would alias into the upper half
		if (sys_glue_pkg::ROM_ADDR_WIDTH > sys_glue_pkg::OVERLAY_TOP_BIT) begin
			$error("system_address_decode: ROM decode wider than the overlay window");
		end
	end

	// Bus cycle decode, the CPU bus runs on mclk
	sys_glue_pkg::bus_cycle_t cycle;
	assign cycle.memAccess = !mreqN && (!rdN || !wrN);
	assign cycle.ioRead = !iorqN && m1N && !rdN;
	assign cycle.ioWrite = !iorqN && m1N && !wrN;
	assign cycle.intAck = !iorqN && !m1N;

	wire logic [7:0] portAddr = cpuAddr[7:0];

	// Write strobe held over several clocks; act on its first cycle only
	logic ioWritePrev_q;
	wire logic ioWriteStart = cycle.ioWrite && !ioWritePrev_q;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ioWritePrev_q <= 1'b0;
		end else begin
			ioWritePrev_q <= cycle.ioWrite;
		end
	end

	// Control registers
	logic [7:0] controlOne_q;
	logic [7:0] controlTwo_q;
	wire logic ctl1Write = ioWriteStart && portAddr == sys_glue_pkg::PORT_SYSTEM_CONTROL_ONE;
	wire logic ctl2Write = ioWriteStart && portAddr == sys_glue_pkg::PORT_SYSTEM_CONTROL_TWO;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			// RL15 start-up values
			// RL1 overlay on at reset
			controlOne_q <= sys_glue_pkg::CTL1_RESET;
			controlTwo_q <= sys_glue_pkg::CTL2_RESET;
		end else begin
			// RL2 overlay switch write
			if (ctl1Write) begin
				controlOne_q <= cpuDataIn;
			end
			if (ctl2Write) begin
				controlTwo_q <= cpuDataIn;
			end
		end
	end

	wire logic romEnable = controlOne_q[sys_glue_pkg::CTL1_ROM_ENABLE_BIT];

	// RL3 overlay window decode
	wire logic lowHalf = cpuAddr <= sys_glue_pkg::OVERLAY_LAST_ADDR;
	wire logic romHit = cycle.memAccess && lowHalf && romEnable;
	// RL9 display memory absent from memory space
	wire logic ramHit = cycle.memAccess && !romHit;

	logic romSelect_q;
	logic ramSelect_q;
	logic [sys_glue_pkg::ROM_ADDR_WIDTH-1:0] romAddr_q;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			romSelect_q <= 1'b0;
			ramSelect_q <= 1'b0;
			romAddr_q <= '0;
		end else begin
			// RL3 one select at a time
			romSelect_q <= romHit;
			ramSelect_q <= ramHit;
			// RL4 sixteen kilobyte ROM decode
			romAddr_q <= cpuAddr[sys_glue_pkg::ROM_ADDR_WIDTH-1:0];
		end
	end

	assign romSelect = romSelect_q;
	assign ramSelect = ramSelect_q;
	assign romAddr = romAddr_q;

	// RL5 bank decode
	logic [BANKS-1:0] bankHit;
	logic [BANKS-1:0] bankSel_q;

	io_bank_decode #(
		.BANKS(BANKS),
		.PORTS_PER_BANK(PORTS_PER_BANK)
	) u_bank_decode (
		.portAddr(portAddr),
		.ioCycle(cycle.ioRead || cycle.ioWrite),
		.bankHit(bankHit)
	);

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			bankSel_q <= '0;
		end else begin
			// RL6 consecutive bank selects
			bankSel_q <= bankHit;
		end
	end

	assign bank0Select = bankSel_q[sys_glue_pkg::BANK_VIDEO];
	assign bank1Select = bankSel_q[1];
	// RL7 floppy bank
	assign bank2Select = bankSel_q[sys_glue_pkg::BANK_FLOPPY];
	assign bank3Select = bankSel_q[sys_glue_pkg::BANK_SYSTEM];
	assign bank4Select = bankSel_q[4];
	assign bank5Select = bankSel_q[5];
	// RL8 hard disk bank
	assign bank6Select = bankSel_q[sys_glue_pkg::BANK_HARD_DISK];
	assign bank7Select = bankSel_q[7];

	// RL9 display buffer written through an I/O port
	logic displayWriteStrobe_q;
	logic [7:0] displayWriteData_q;
	wire logic displayWrite = ioWriteStart && portAddr == sys_glue_pkg::PORT_DISPLAY_BUFFER_WRITE;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			displayWriteStrobe_q <= 1'b0;
			displayWriteData_q <= 8'h00;
		end else begin
			displayWriteStrobe_q <= displayWrite;
			if (displayWrite) begin
				displayWriteData_q <= cpuDataIn;
			end
		end
	end

	assign displayWriteStrobe = displayWriteStrobe_q;
	assign displayWriteData = displayWriteData_q;
	assign controlTwo = controlTwo_q;

	// Peripheral requests come from pins: two-stage synchronisers
	// RL11 two floppy sources
	// RL12 one video source
	// RL13 a source's index is its rank, index 0 served first
	logic [IRQ_SOURCES-1:0] irqRaw;
	always_comb begin
		irqRaw = '0;
		irqRaw[sys_glue_pkg::IRQ_DISK_DATA] = diskDataRequest;
		irqRaw[sys_glue_pkg::IRQ_DISK_DONE] = diskCommandDoneIrq;
		irqRaw[sys_glue_pkg::IRQ_VIDEO] = videoIrq;
		irqRaw[sys_glue_pkg::IRQ_KEYBOARD] = keyboardIrq;
		irqRaw[sys_glue_pkg::IRQ_TIMER] = timerIrq;
		irqRaw[sys_glue_pkg::IRQ_CARD_J8] = cardJ8Irq;
		irqRaw[sys_glue_pkg::IRQ_CARD_J7] = cardJ7Irq;
		irqRaw[sys_glue_pkg::IRQ_BUS_J1] = busJ1Irq;
	end
	logic [IRQ_SOURCES-1:0] irqMeta_q;
	logic [IRQ_SOURCES-1:0] irqSync_q;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			irqMeta_q <= '0;
			irqSync_q <= '0;
		end else begin
			irqMeta_q <= irqRaw;
			irqSync_q <= irqMeta_q;
		end
	end

	// RL13 fixed priority
	logic irqAny;
	logic [sys_glue_pkg::IRQ_INDEX_WIDTH-1:0] irqTop;

	irq_priority #(
		.SOURCES(IRQ_SOURCES),
		.INDEX_WIDTH(sys_glue_pkg::IRQ_INDEX_WIDTH)
	) u_irq_priority (
		.request(irqSync_q),
		.anyPending(irqAny),
		.topIndex(irqTop)
	);

	// Acknowledge is a held M1+IORQ cycle; latch on its first clock
	logic ackPrev_q;
	wire logic ackStart = cycle.intAck && !ackPrev_q;

	sys_glue_pkg::irq_state_t irqState_q;
	sys_glue_pkg::irq_state_t irqState_d;
	logic [sys_glue_pkg::IRQ_INDEX_WIDTH-1:0] serviceIndex_q;
	logic intReqN_q;

	wire logic serviceDone = !irqSync_q[serviceIndex_q];
	wire logic inService = irqState_q == sys_glue_pkg::IRQ_SERVICE;

	// RL17 one source at a time
	always_comb begin
		irqState_d = irqState_q;
		case (irqState_q)
			sys_glue_pkg::IRQ_IDLE: begin
				if (irqAny) begin
					irqState_d = sys_glue_pkg::IRQ_REQUEST;
				end
			end
			sys_glue_pkg::IRQ_REQUEST: begin
				if (ackStart && irqAny) begin
					irqState_d = sys_glue_pkg::IRQ_SERVICE;
				end else if (!irqAny) begin
					irqState_d = sys_glue_pkg::IRQ_IDLE;
				end
			end
			sys_glue_pkg::IRQ_SERVICE: begin
				if (serviceDone) begin
					irqState_d = sys_glue_pkg::IRQ_IDLE;
				end
			end
			default: begin
				irqState_d = sys_glue_pkg::IRQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			irqState_q <= sys_glue_pkg::IRQ_IDLE;
			serviceIndex_q <= '0;
			ackPrev_q <= 1'b0;
			intReqN_q <= 1'b1;
		end else begin
			irqState_q <= irqState_d;
			ackPrev_q <= cycle.intAck;
			// RL17 latch the winner at acknowledge
			if (irqState_q == sys_glue_pkg::IRQ_REQUEST && ackStart && irqAny) begin
				serviceIndex_q <= irqTop;
			end
			intReqN_q <= !(irqState_d == sys_glue_pkg::IRQ_REQUEST);
		end
	end

	assign intReqN = intReqN_q;

	// RL14 vector low byte indexes the two-byte table entries
	wire logic [7:0] vectorByte = sys_glue_pkg::VECTOR_TABLE_LOW
		| {4'h0, irqTop, 1'b0};

	// RL16 status shows overlay and interrupt state
	logic [7:0] statusByte;
	always_comb begin
		statusByte = 8'h00;
		statusByte[sys_glue_pkg::STAT_ROM_ENABLE_BIT] = romEnable;
		statusByte[sys_glue_pkg::STAT_PENDING_BIT] = irqAny;
		statusByte[sys_glue_pkg::STAT_IN_SERVICE_BIT] = inService;
		statusByte[sys_glue_pkg::STAT_REQUEST_BIT] = !intReqN_q;
		statusByte[sys_glue_pkg::STAT_TOP_INDEX_LSB +: sys_glue_pkg::IRQ_INDEX_WIDTH] = irqTop;
	end
	wire logic statusRead = cycle.ioRead && portAddr == sys_glue_pkg::PORT_SYSTEM_STATUS;
	wire logic vectorDrive = cycle.intAck && irqState_q == sys_glue_pkg::IRQ_REQUEST;

	logic [7:0] cpuDataOut_q;
	logic cpuDataOe_q;
	logic [7:0] vectorHeld_q;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cpuDataOut_q <= 8'h00;
			cpuDataOe_q <= 1'b0;
			vectorHeld_q <= 8'h00;
		end else begin
			if (ackStart) begin
				vectorHeld_q <= vectorByte;
			end
			cpuDataOe_q <= statusRead || (cycle.intAck && (vectorDrive || inService));
			if (statusRead) begin
				cpuDataOut_q <= statusByte;
			end else if (cycle.intAck) begin
				cpuDataOut_q <= ackStart ? vectorByte : vectorHeld_q;
			end
		end
	end

	assign cpuDataOut = cpuDataOut_q;
	assign cpuDataOe = cpuDataOe_q;

	// RL10 no bus request or grant path exists; all transfers are programmed

endmodule

`default_nettype wire

// ### shared/sys_glue_pkg.sv
`default_nettype none
package sys_glue_pkg;

	// CPU memory map
	localparam logic [15:0] OVERLAY_LAST_ADDR = 16'h7FFF;
	localparam int OVERLAY_TOP_BIT = 15;
	localparam int ROM_ADDR_WIDTH = 14;

	// I/O port space split into banks
	localparam int BANK_COUNT = 8;
	localparam int PORTS_PER_BANK = 8;
	localparam int PORT_ADDR_WIDTH = 8;
	localparam logic [7:0] BANK_SPACE_LAST_PORT = 8'h3F;
	localparam int BANK_VIDEO = 0;
	localparam int BANK_FLOPPY = 2;
	localparam int BANK_SYSTEM = 3;
	localparam int BANK_HARD_DISK = 6;

	// Internal system ports
	localparam logic [7:0] PORT_SYSTEM_STATUS = 8'h18;
	localparam logic [7:0] PORT_SYSTEM_CONTROL_ONE = 8'h18;
	localparam logic [7:0] PORT_DISPLAY_BUFFER_WRITE = 8'h1C;
	localparam logic [7:0] PORT_SYSTEM_CONTROL_TWO = 8'h1D;

	// Control one fields and start-up values
	localparam int CTL1_ROM_ENABLE_BIT = 0;
	localparam logic [7:0] CTL1_RESET = 8'h01;
	localparam logic [7:0] CTL2_RESET = 8'h00;

	// Status fields
	localparam int STAT_ROM_ENABLE_BIT = 0;
	localparam int STAT_PENDING_BIT = 1;
	localparam int STAT_IN_SERVICE_BIT = 2;
	localparam int STAT_REQUEST_BIT = 3;
	localparam int STAT_TOP_INDEX_LSB = 4;

	// Interrupt sources, index 0 is the highest priority
	localparam int IRQ_COUNT = 8;
	localparam int IRQ_INDEX_WIDTH = 3;
	localparam int IRQ_DISK_DATA = 0;
	localparam int IRQ_DISK_DONE = 1;
	localparam int IRQ_VIDEO = 2;
	localparam int IRQ_KEYBOARD = 3;
	localparam int IRQ_TIMER = 4;
	localparam int IRQ_CARD_J8 = 5;
	localparam int IRQ_CARD_J7 = 6;
	localparam int IRQ_BUS_J1 = 7;

	// Each vector entry is two bytes in a sixteen byte table
	localparam logic [7:0] VECTOR_TABLE_LOW = 8'h00;

	typedef struct packed {
		logic memAccess;
		logic ioRead;
		logic ioWrite;
		logic intAck;
	} bus_cycle_t;

	typedef enum logic [2:0] {
		IRQ_IDLE = 3'b001,
		IRQ_REQUEST = 3'b010,
		IRQ_SERVICE = 3'b100
	} irq_state_t;

endpackage
`default_nettype wire

// ### core/io_bank_decode.sv
`timescale 1ns/100ps
`default_nettype none

module io_bank_decode #(
	parameter int BANKS = 8,
	parameter int PORTS_PER_BANK = 8
) (
	input wire logic [7:0] portAddr,
	input wire logic ioCycle,
	output logic [BANKS-1:0] bankHit
);

	localparam int PORT_BITS = $clog2(PORTS_PER_BANK);
	localparam int BANK_BITS = $clog2(BANKS);

	initial begin
		if (BANKS * PORTS_PER_BANK > 256 || BANKS < 2 || PORTS_PER_BANK < 2) begin
			$error("io_bank_decode: bank geometry does not fit the port space");
		end
	end

	wire logic inRange = (portAddr >> (PORT_BITS + BANK_BITS)) == 8'h00;
	wire logic [BANK_BITS-1:0] bankIndex = portAddr[PORT_BITS +: BANK_BITS];

	genvar b;
	generate
		for (b = 0; b < BANKS; b++) begin : g_bank
			assign bankHit[b] = ioCycle && inRange && (bankIndex == BANK_BITS'(b));
		end
	endgenerate

endmodule

`default_nettype wire

// ### core/irq_priority.sv
`timescale 1ns/100ps
`default_nettype none

module irq_priority #(
	parameter int SOURCES = 8,
	parameter int INDEX_WIDTH = 3
) (
	input wire logic [SOURCES-1:0] request,
	output logic anyPending,
	output logic [INDEX_WIDTH-1:0] topIndex
);

	initial begin
		if (SOURCES > (1 << INDEX_WIDTH) || SOURCES < 1) begin
			$error("irq_priority: index too narrow for source count");
		end
	end

	assign anyPending = |request;

	// Lowest index wins, so scan from the bottom priority upward
	always_comb begin
		topIndex = '0;
		for (int i = SOURCES - 1; i >= 0; i--) begin
			if (request[i]) begin
				topIndex = INDEX_WIDTH'(i);
			end
		end
	end

endmodule

`default_nettype wire

// ### tb/system_address_decode_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module system_address_decode_monitor (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [15:0] cpuAddr,
	input wire logic iorqN,
	input wire logic m1N,
	input wire logic romSelect,
	input wire logic ramSelect,
	input wire logic [sys_glue_pkg::ROM_ADDR_WIDTH-1:0] romAddr,
	input wire logic bank0Select,
	input wire logic bank2Select,
	input wire logic bank6Select,
	input wire logic displayWriteStrobe,
	input wire logic [7:0] cpuDataOut,
	input wire logic cpuDataOe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	chk_select_exclusive: assert property (!(romSelect && ramSelect))
		else $error("rom and ram selected together");
	chk_rom_window: assert property (romSelect |-> !$past(cpuAddr[15]))
		else $error("rom selected above 7FFF");
	chk_rom_address: assert property (romSelect |-> romAddr == $past(cpuAddr[13:0]))
		else $error("rom address mismatch");
	chk_bank_cycle: assert property ((bank0Select || bank2Select || bank6Select) |-> $past(!iorqN && m1N))
		else $error("bank select outside io cycle");
	chk_bank0_ports: assert property (bank0Select |-> $past(cpuAddr[7:3]) == 5'h00)
		else $error("bank 0 wrong port");
	chk_floppy_ports: assert property (bank2Select |-> $past(cpuAddr[7:3]) == 5'h02)
		else $error("bank 2 wrong port");
	chk_disk_ports: assert property (bank6Select |-> $past(cpuAddr[7:3]) == 5'h06)
		else $error("bank 6 wrong port");
	chk_strobe_single: assert property (displayWriteStrobe |=> !displayWriteStrobe)
		else $error("display strobe too long");
	chk_vector_form: assert property ((cpuDataOe && !m1N) |-> cpuDataOut[7:4] == 4'h0 && !cpuDataOut[0])
		else $error("vector outside table");
	cover property (romSelect);
	cover property (bank6Select);
	cover property (cpuDataOe && !m1N);
endmodule
bind system_address_decode system_address_decode_monitor system_address_decode_monitor_i (.mclk, .sys_rst,
	.cpuAddr, .iorqN, .m1N, .romSelect, .ramSelect, .romAddr, .bank0Select, .bank2Select, .bank6Select,
	.displayWriteStrobe, .cpuDataOut, .cpuDataOe);
`default_nettype wire

// ### tb/cpu_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model (
	input wire logic mclk,
	output logic [15:0] cpuAddr,
	output logic [7:0] cpuDataIn,
	output logic mreqN,
	output logic iorqN,
	output logic rdN,
	output logic wrN,
	output logic m1N
);
	initial begin
		cpuAddr = 16'hFFFF;
		cpuDataIn = 8'hFF;
		{mreqN, iorqN, rdN, wrN, m1N} = 5'h1F;
	end
	task automatic start(input sys_glue_pkg::bus_cycle_t k, input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		cpuAddr <= a;
		cpuDataIn <= d;
		mreqN <= !k.memAccess;
		iorqN <= !(k.ioRead || k.ioWrite || k.intAck);
		rdN <= !(k.memAccess || k.ioRead);
		wrN <= !k.ioWrite;
		m1N <= !k.intAck;
		@(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic finish();
		@(posedge mclk);
		{mreqN, iorqN, rdN, wrN, m1N} <= 5'h1F;
		cpuAddr <= ~cpuAddr;
		cpuDataIn <= ~cpuDataIn;
		@(posedge mclk);
	endtask
endmodule
`default_nettype wire

// ### tb/system_address_decode_tb.sv
`timescale 1ns/100ps
`default_nettype none
module system_address_decode_tb;
	localparam sys_glue_pkg::bus_cycle_t MEM = 4'h8;
	localparam sys_glue_pkg::bus_cycle_t IORD = 4'h4;
	localparam sys_glue_pkg::bus_cycle_t IOWR = 4'h2;
	localparam sys_glue_pkg::bus_cycle_t ACK = 4'h1;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] irq = 8'h00;
	logic [15:0] cpuAddr;
	logic [7:0] cpuDataIn, cpuDataOut, displayWriteData, controlTwo, banks, strobeData;
	logic mreqN, iorqN, rdN, wrN, m1N, cpuDataOe, intReqN, romSelect, ramSelect, displayWriteStrobe;
	logic bank0Select, bank1Select, bank2Select, bank3Select, bank4Select, bank5Select, bank6Select, bank7Select;
	logic [sys_glue_pkg::ROM_ADDR_WIDTH-1:0] romAddr;
	int error_cnt = 0;
	int total_checks = 0;
	int strobeCnt = 0;
	assign banks = {bank7Select, bank6Select, bank5Select, bank4Select, bank3Select, bank2Select, bank1Select,
		bank0Select};
	cpu_bus_model cpu_bus_model_i (.mclk, .cpuAddr, .cpuDataIn, .mreqN, .iorqN, .rdN, .wrN, .m1N);
	system_address_decode system_address_decode_i (.mclk, .sys_rst, .cpuAddr, .cpuDataIn, .mreqN, .iorqN, .rdN,
		.wrN, .m1N, .cpuDataOut, .cpuDataOe, .intReqN, .diskDataRequest(irq[0]), .diskCommandDoneIrq(irq[1]),
		.videoIrq(irq[2]), .keyboardIrq(irq[3]), .timerIrq(irq[4]), .cardJ8Irq(irq[5]), .cardJ7Irq(irq[6]),
		.busJ1Irq(irq[7]), .romSelect, .ramSelect, .romAddr, .bank0Select, .bank1Select, .bank2Select,
		.bank3Select, .bank4Select, .bank5Select, .bank6Select, .bank7Select, .displayWriteStrobe,
		.displayWriteData, .controlTwo);
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (displayWriteStrobe === 1'b1) begin
			strobeCnt++;
			strobeData = displayWriteData;
		end
	end
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic mem_probe(input logic [15:0] a, input logic rom);
		cpu_bus_model_i.start(MEM, a, 8'h00);
		chk("memory select", {14'h0, romSelect, ramSelect}, {14'h0, rom, !rom});
		if (rom) chk("rom address", {2'h0, romAddr}, {2'h0, a[13:0]});
		cpu_bus_model_i.finish();
	endtask
	task automatic io_access(input sys_glue_pkg::bus_cycle_t k, input logic [7:0] p, input logic [7:0] d);
		cpu_bus_model_i.start(k, {8'h00, p}, d);
		chk("bank selects", {8'h0, banks}, {8'h0, (p < 8'h40) ? 8'h01 << p[5:3] : 8'h00});
		if (k == IORD && p == 8'h18) chk("status", {7'h0, cpuDataOe, cpuDataOut}, {8'h01, d});
		cpu_bus_model_i.finish();
	endtask
	task automatic test_boot();
		chk("control two", {8'h0, controlTwo}, 16'h0000);
		io_access(IORD, 8'h18, 8'h01);
		mem_probe(16'h7FFF, 1'b1);
		mem_probe(16'h8000, 1'b0);
		io_access(IOWR, 8'h18, 8'h00);
		mem_probe(16'h0000, 1'b0);
		io_access(IORD, 8'h18, 8'h00);
		io_access(IOWR, 8'h18, 8'h01);
		mem_probe(16'h1234, 1'b1);
		$display("boot and overlay test done");
	endtask
	task automatic test_banks();
		for (int b = 0; b < 8; b++) begin
			io_access((b % 2) ? IOWR : IORD, 8'(b * 8 + (b % 2) * 7), 8'h00);
		end
		io_access(IORD, 8'h40, 8'h00);
		io_access(IOWR, 8'hFF, 8'h00);
		io_access(IOWR, 8'h1C, 8'hA5);
		chk("display strobe", {8'(strobeCnt), strobeData}, 16'h01A5);
		io_access(IOWR, 8'h1D, 8'h5A);
		chk("control two", {8'(strobeCnt), controlTwo}, 16'h015A);
		$display("bank and register test done");
	endtask
	task automatic test_reset();
		io_access(IOWR, 8'h18, 8'h00);
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		chk("control two", {8'h0, controlTwo}, 16'h0000);
		io_access(IORD, 8'h18, 8'h01);
		mem_probe(16'h0000, 1'b1);
		$display("reset test done");
	endtask
	task automatic test_irq();
		int n;
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk);
			irq <= 8'(1 << i) | 8'h80;
			n = 0;
			while (intReqN !== 1'b0 && n < 20) begin
				@(posedge mclk);
				n++;
			end
			@(negedge mclk);
			chk("request", {15'h0, intReqN}, 16'h0000);
			io_access(IORD, 8'h18, {1'b0, 3'(i), 4'hB});
			cpu_bus_model_i.start(ACK, 16'h0000, 8'h00);
			chk("vector", {8'hFB, cpuDataOut}, 16'hFB00 + 16'(i * 2));
			chk("vector enable", {15'h0, cpuDataOe}, 16'h0001);
			cpu_bus_model_i.finish();
			@(negedge mclk);
			chk("request", {15'h0, intReqN}, 16'h0001);
			@(posedge mclk);
			irq <= 8'h80;
			repeat (5) @(posedge mclk);
			@(negedge mclk);
			chk("deferred request", {15'h0, intReqN}, {15'h0, i == 7});
			@(posedge mclk);
			irq <= 8'h00;
			repeat (4) @(posedge mclk);
		end
		$display("interrupt test done");
	endtask
	initial begin
		#125000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		test_boot();
		test_banks();
		test_reset();
		test_irq();
		print_verdict();
	end
endmodule
`default_nettype wire
